// *** hw/cspmc_pkg.sv ***
package cspmc_pkg;

  localparam logic [9:0] ADDR_PLL_CTRL   = 10'h010;
  localparam logic [9:0] ADDR_VCO_CAL    = 10'h018;
  localparam logic [9:0] ADDR_REF_EN     = 10'h01C;
  localparam logic [9:0] ADDR_VCO_DIV    = 10'h1E0;
  localparam logic [9:0] ADDR_SRC_ROUTE  = 10'h1E1;
  localparam logic [9:0] ADDR_APPLY      = 10'h232;

  localparam int POS_PLL_PWR_LO  = 0;
  localparam int POS_PFD_POL     = 7;
  localparam int POS_CAL         = 0;
  localparam int POS_BYPASS      = 0;
  localparam int POS_SRC_VCO     = 1;
  localparam int POS_APPLY       = 0;

  localparam logic [1:0] PLL_PWR_NORMAL = 2'h0;
  localparam logic [1:0] PLL_PWR_DOWN   = 2'h1;

  localparam logic [7:0] RST_PLL_CTRL  = 8'h01;
  localparam logic [7:0] RST_VCO_CAL   = 8'h00;
  localparam logic [7:0] RST_REF_EN    = 8'h00;
  localparam logic [7:0] RST_VCO_DIV   = 8'h00;
  localparam logic [7:0] RST_SRC_ROUTE = 8'h00;

  localparam int NUM_REGS = 5;
  localparam logic [2:0] NV_LAST_IDX = 3'h4;

  typedef struct packed {
    logic [7:0] pll_ctrl;
    logic [7:0] vco_cal;
    logic [7:0] ref_en;
    logic [7:0] vco_div;
    logic [7:0] src_route;
  } cspmc_regs_t;

  typedef struct packed {
    logic       pll_powered;
    logic       pfd_negative;
    logic       vco_selected;
    logic       vco_powered;
    logic       divider_bypass;
    logic [2:0] vco_div_code;
    logic [2:0] ref_enable;
  } cspmc_ctrl_t;

  localparam cspmc_regs_t RST_REGS = '{RST_PLL_CTRL, RST_VCO_CAL, RST_REF_EN, RST_VCO_DIV, RST_SRC_ROUTE};

endpackage

// *** hw/cspmc_top.sv ***
`timescale 1ns/10ps
// Summary of operation
// R1: PLL power field 00b runs the PLL, 01b powers it down asynchronously.
// R2: Source bit 1 routes internal VCO, 0 routes external CLK input.
// R3: Bypass bit 0 uses VCO divider output, 1 passes the source directly.
// R4: Calibration starts when an update applies a calibration bit of 1.
// R5: Host clears calibration bit and updates before requesting a new calibration.
// R6: Host may skip that clear only for the first calibration after power-up.
// R7: PFD polarity bit 0 is positive, 1 is negative.
// R8: Host uses VCO divider with internal VCO unless direct mode or <=1600 MHz.
// R9: Host bypasses the VCO divider only below 1600 MHz source frequency.
// R10: Host runs calibration whenever the internal VCO is selected.
// R11: Three-bit field enables reference inputs; disabled inputs stay unused.
// R12: With external VCO below 1600 MHz, host sets PLL to normal operation.
// R13: Settings can be saved to nonvolatile storage and reload at power-up.
// R14: Reset defaults are PLL down, divider code 000b, divider used, CLK selected.
// R15: With CLK selected, the internal VCO is unused and powered off.
// R16: Writes are staged and applied on update strobe, which self-clears.
module cspmc_top (
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire logic [9:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  output logic      [7:0]           reg_rdata_out,
  input  wire logic                 nv_save_in,
  output logic                      nv_busy_out,
  output logic                      nv_wr_out,
  output logic      [2:0]           nv_addr_out,
  output logic      [7:0]           nv_wdata_out,
  input  wire logic [7:0]           nv_rdata_in,
  output cspmc_pkg::cspmc_ctrl_t    ctrl_out,
  output logic                      cal_start_out
);

  typedef enum logic [2:0] {
    CSPMC_LOAD = 3'h1,
    CSPMC_IDLE = 3'h2,
    CSPMC_SAVE = 3'h4
  } cspmc_state_t;

  cspmc_pkg::cspmc_regs_t stage;
  cspmc_pkg::cspmc_regs_t active;
  cspmc_state_t           state;
  logic [2:0]             nv_idx;
  logic                   cal_prev;
  logic [7:0]             stg_pll_ctrl;
  logic [7:0]             stg_vco_cal;
  logic [7:0]             stg_ref_en;
  logic [7:0]             stg_vco_div;
  logic [7:0]             stg_src_route;
  logic [7:0]             act_pll_ctrl;
  logic [7:0]             act_vco_cal;
  logic [7:0]             act_ref_en;
  logic [7:0]             act_vco_div;
  logic [7:0]             act_src_route;
  logic                   host_wr;
  logic [2:0]             wr_idx;
  logic                   load_step;
  logic                   load_last;
  logic [4:0]             load_hit;
  logic [4:0]             wr_hit;

  function automatic logic [7:0] reg_pick(input cspmc_pkg::cspmc_regs_t r, input logic [2:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      3'h0:    v = r.pll_ctrl;
      3'h1:    v = r.vco_cal;
      3'h2:    v = r.ref_en;
      3'h3:    v = r.vco_div;
      3'h4:    v = r.src_route;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic [2:0] addr_idx(input logic [9:0] a);
    logic [2:0] i;
    i = 3'h7;
    case (a)
      cspmc_pkg::ADDR_PLL_CTRL:  i = 3'h0;
      cspmc_pkg::ADDR_VCO_CAL:   i = 3'h1;
      cspmc_pkg::ADDR_REF_EN:    i = 3'h2;
      cspmc_pkg::ADDR_VCO_DIV:   i = 3'h3;
      cspmc_pkg::ADDR_SRC_ROUTE: i = 3'h4;
      default:                   i = 3'h7;
    endcase
    return i;
  endfunction

  logic apply;
  assign apply = reg_wr_in && (state == CSPMC_IDLE) && (reg_addr_in == cspmc_pkg::ADDR_APPLY)
                 && reg_wdata_in[cspmc_pkg::POS_APPLY];

  // Host write and load step qualifiers
  assign host_wr   = reg_wr_in && (state == CSPMC_IDLE); // R16
  assign wr_idx    = addr_idx(reg_addr_in);
  assign load_step = (state == CSPMC_LOAD);
  assign load_last = load_step && (nv_idx == cspmc_pkg::NV_LAST_IDX); // R13

  // Staged and active words gathered in register order
  assign stage  = {stg_pll_ctrl, stg_vco_cal, stg_ref_en, stg_vco_div, stg_src_route};
  assign active = {act_pll_ctrl, act_vco_cal, act_ref_en, act_vco_div, act_src_route};

  // One-hot word selects for the nonvolatile load and for host writes
  always_comb begin
    load_hit = 5'h00;
    wr_hit   = 5'h00;
    for (int w = 0; w < cspmc_pkg::NUM_REGS; w++) begin
      load_hit[w] = load_step && (nv_idx == 3'(w));
      wr_hit[w]   = host_wr && (wr_idx == 3'(w));
    end
  end

  // Nonvolatile load at reset release, save on request
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state  <= CSPMC_LOAD;
      nv_idx <= 3'h0;
    end else begin
      case (state)
        CSPMC_LOAD: begin
          nv_idx <= nv_idx + 3'h1;
          if (nv_idx == cspmc_pkg::NV_LAST_IDX) begin // R13
            state  <= CSPMC_IDLE;
            nv_idx <= 3'h0;
          end
        end
        CSPMC_IDLE: begin
          if (nv_save_in) begin // R13
            state <= CSPMC_SAVE;
          end
        end
        CSPMC_SAVE: begin
          nv_idx <= nv_idx + 3'h1;
          if (nv_idx == cspmc_pkg::NV_LAST_IDX) begin
            state  <= CSPMC_IDLE;
            nv_idx <= 3'h0;
          end
        end
        default: begin
          state  <= CSPMC_IDLE;
          nv_idx <= 3'h0;
        end
      endcase
    end
  end

  // Staged PLL power and polarity word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stg_pll_ctrl <= cspmc_pkg::RST_PLL_CTRL; // R14
    end else if (load_hit[0]) begin
      stg_pll_ctrl <= nv_rdata_in; // R13
    end else if (wr_hit[0]) begin
      stg_pll_ctrl <= reg_wdata_in; // R16
    end
  end

  // Staged calibration word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stg_vco_cal <= cspmc_pkg::RST_VCO_CAL; // R14
    end else if (load_hit[1]) begin
      stg_vco_cal <= nv_rdata_in; // R13
    end else if (wr_hit[1]) begin
      stg_vco_cal <= reg_wdata_in; // R16
    end
  end

  // Staged reference enable word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stg_ref_en <= cspmc_pkg::RST_REF_EN; // R14
    end else if (load_hit[2]) begin
      stg_ref_en <= nv_rdata_in; // R13
    end else if (wr_hit[2]) begin
      stg_ref_en <= reg_wdata_in; // R16
    end
  end

  // Staged divider word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stg_vco_div <= cspmc_pkg::RST_VCO_DIV; // R14
    end else if (load_hit[3]) begin
      stg_vco_div <= nv_rdata_in; // R13
    end else if (wr_hit[3]) begin
      stg_vco_div <= reg_wdata_in; // R16
    end
  end

  // Staged source routing word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stg_src_route <= cspmc_pkg::RST_SRC_ROUTE; // R14
    end else if (load_hit[4]) begin
      stg_src_route <= nv_rdata_in; // R13
    end else if (wr_hit[4]) begin
      stg_src_route <= reg_wdata_in; // R16
    end
  end

  // Active PLL power and polarity word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_pll_ctrl <= cspmc_pkg::RST_PLL_CTRL; // R14
    end else if (apply || load_last) begin
      act_pll_ctrl <= stg_pll_ctrl; // R16
    end
  end

  // Active calibration word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_vco_cal <= cspmc_pkg::RST_VCO_CAL; // R14
    end else if (apply || load_last) begin
      act_vco_cal <= stg_vco_cal; // R16
    end
  end

  // Active reference enable word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_ref_en <= cspmc_pkg::RST_REF_EN; // R14
    end else if (apply || load_last) begin
      act_ref_en <= stg_ref_en; // R16
    end
  end

  // Active divider word
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_vco_div <= cspmc_pkg::RST_VCO_DIV; // R14
    end else if (apply || load_last) begin
      act_vco_div <= stg_vco_div; // R16
    end
  end

  // Active routing word, last load word taken straight from the store
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_src_route <= cspmc_pkg::RST_SRC_ROUTE; // R14
    end else if (load_last) begin
      act_src_route <= nv_rdata_in; // R13
    end else if (apply) begin
      act_src_route <= stg_src_route; // R16
    end
  end

  // Applied calibration bit, one cycle late
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cal_prev <= 1'b0;
    end else begin
      cal_prev <= active.vco_cal[cspmc_pkg::POS_CAL];
    end
  end

  // Calibration start on applied 0-to-1 of calibration bit
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cal_start_out <= 1'b0;
    end else begin
      cal_start_out <= active.vco_cal[cspmc_pkg::POS_CAL] && !cal_prev; // R4
    end
  end

  // Register read, apply bit reads zero as it self-clears
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= reg_pick(stage, addr_idx(reg_addr_in)); // R16
    end
  end

  // Active control decode
  always_comb begin
    ctrl_out.pll_powered    = (active.pll_ctrl[1:0] == cspmc_pkg::PLL_PWR_NORMAL); // R1
    ctrl_out.pfd_negative   = active.pll_ctrl[cspmc_pkg::POS_PFD_POL]; // R7
    ctrl_out.vco_selected   = active.src_route[cspmc_pkg::POS_SRC_VCO]; // R2
    ctrl_out.vco_powered    = active.src_route[cspmc_pkg::POS_SRC_VCO]; // R15
    ctrl_out.divider_bypass = active.src_route[cspmc_pkg::POS_BYPASS]; // R3
    ctrl_out.vco_div_code   = active.vco_div[2:0];
    ctrl_out.ref_enable     = active.ref_en[2:0]; // R11
  end

  assign nv_busy_out  = (state != CSPMC_IDLE);
  assign nv_wr_out    = (state == CSPMC_SAVE); // R13
  assign nv_addr_out  = nv_idx;

  // Save data word, prepared one step ahead of its index
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nv_wdata_out <= 8'h00;
    end else if (state == CSPMC_SAVE) begin
      nv_wdata_out <= reg_pick(active, nv_idx + 3'h1); // R13
    end else begin
      nv_wdata_out <= reg_pick(active, 3'h0);
    end
  end

endmodule

// *** sim/cspmc_props.sv ***
`timescale 1ns/10ps
module cspmc_props (
  input wire logic                   clk_sys_in,
  input wire logic                   reset_n_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [9:0]             reg_addr_in,
  input wire logic [7:0]             reg_wdata_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic                   nv_busy_out,
  input wire logic                   nv_wr_out,
  input wire logic [2:0]             nv_addr_out,
  input wire cspmc_pkg::cspmc_ctrl_t ctrl_out,
  input wire logic                   cal_start_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  wire upd = reg_wr_in && !nv_busy_out && reg_addr_in == cspmc_pkg::ADDR_APPLY && reg_wdata_in[0];
  a_ctrl_staged: assert property (!upd && !nv_busy_out |=> $stable(ctrl_out))
    else $error("ctrl moved without update");
  a_vco_off: assert property (ctrl_out.vco_powered == ctrl_out.vco_selected)
    else $error("vco power differs from select");
  a_cal_cause: assert property (cal_start_out |-> $past(upd, 2) || $past(upd, 3) || $past(nv_busy_out, 3))
    else $error("cal start without update");
  a_cal_single: assert property (cal_start_out |=> !cal_start_out)
    else $error("cal start longer than one cycle");
  a_apply_rd0: assert property (reg_rd_in && reg_addr_in == cspmc_pkg::ADDR_APPLY |=> reg_rdata_out == 8'h00)
    else $error("apply strobe reads nonzero");
  a_save_burst: assert property ($rose(nv_wr_out) |-> nv_addr_out == 3'h0 ##0 nv_wr_out [*5] ##1 !nv_wr_out)
    else $error("save burst wrong");
  a_save_busy: assert property (nv_wr_out |-> nv_busy_out)
    else $error("save while idle");
  a_load_done: assert property ($rose(reset_n_in) |-> ##[1:6] !nv_busy_out)
    else $error("load too long");
  a_reset_dflt: assert property ($rose(reset_n_in) |-> !ctrl_out.pll_powered && !ctrl_out.vco_selected
    && !ctrl_out.divider_bypass && ctrl_out.vco_div_code == 3'h0)
    else $error("reset defaults wrong");
  c_update: cover property (upd);
  c_cal: cover property (cal_start_out);
  c_save: cover property ($rose(nv_wr_out));
endmodule

// *** sim/cspmc_nv_model.sv ***
`timescale 1ns/10ps
module cspmc_nv_model (
  input  wire logic       clk_sys_in,
  input  wire logic       nv_wr_out,
  input  wire logic [2:0] nv_addr_out,
  input  wire logic [7:0] nv_wdata_out,
  output logic      [7:0] nv_rdata_in
);
  logic [7:0] mem [5] = '{8'h80, 8'h00, 8'h05, 8'h03, 8'h01};
  // Same-cycle read, write on the clock
  assign nv_rdata_in = mem[nv_addr_out];
  always @(posedge clk_sys_in) begin
    if (nv_wr_out) mem[nv_addr_out] <= nv_wdata_out;
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, s) begin \
  tests_run++; \
  if ((s) !== (e)) begin \
    error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); \
  end \
end
module tb;
  logic                   clk_sys_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, nv_save_in = 0;
  logic [9:0]             reg_addr_in = 10'h000;
  logic [7:0]             reg_wdata_in = 8'h00, reg_rdata_out, nv_wdata_out, nv_rdata_in, d;
  logic                   nv_busy_out, nv_wr_out, cal_start_out;
  logic [2:0]             nv_addr_out;
  cspmc_pkg::cspmc_ctrl_t ctrl_out, exp_c;
  int                     error_cnt = 0, tests_run = 0, n;
  cspmc_top u_dut (.*);
  cspmc_nv_model u_nv (.*);
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys_in) #1;
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = v;
    @(posedge clk_sys_in) #1;
    reg_wr_in = 0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys_in) #1;
    reg_rd_in = 1;
    reg_addr_in = a;
    @(posedge clk_sys_in) #1;
    reg_rd_in = 0;
    d = reg_rdata_out;
  endtask
  task automatic idle();
    for (n = 0; n < 20 && nv_busy_out !== 1'b0; n++) @(posedge clk_sys_in) #1;
    if (n == 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic cal(input logic [7:0] v, input int e);
    wr(cspmc_pkg::ADDR_VCO_CAL, v);
    wr(cspmc_pkg::ADDR_APPLY, 8'h01);
    n = 0;
    repeat (6) begin
      @(posedge clk_sys_in) #1;
      if (cal_start_out !== 1'b0) n++;
    end
    `CHK("cal_start", e, n)
  endtask
  task automatic t_load();
    idle();
    exp_c = 11'h65D;
    `CHK("load", exp_c, ctrl_out)
  endtask
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      wr(cspmc_pkg::ADDR_PLL_CTRL, {i[1] ^ i[0], 6'h00, i[1]});
      wr(cspmc_pkg::ADDR_SRC_ROUTE, {6'h00, i[0], i[1]});
      wr(cspmc_pkg::ADDR_REF_EN, {5'h00, 3'(i + 1)});
      wr(cspmc_pkg::ADDR_VCO_DIV, {5'h00, 3'(3 - i)});
      `CHK("staged", exp_c, ctrl_out)
      wr(cspmc_pkg::ADDR_APPLY, 8'h01);
      @(posedge clk_sys_in) #1;
      exp_c = '{!i[1], i[1] ^ i[0], i[0], i[0], i[1], 3'(3 - i), 3'(i + 1)};
      `CHK("ctrl", exp_c, ctrl_out)
      rd(cspmc_pkg::ADDR_SRC_ROUTE);
      `CHK("rd_route", {6'h00, i[0], i[1]}, d)
    end
    rd(cspmc_pkg::ADDR_APPLY);
    `CHK("rd_apply", 8'h00, d)
  endtask
  task automatic t_cal();
    cal(8'h01, 1);
    cal(8'h01, 0);
    cal(8'h00, 0);
    cal(8'h01, 1);
  endtask
  task automatic t_save();
    @(posedge clk_sys_in) #1;
    nv_save_in = 1;
    @(posedge clk_sys_in) #1;
    nv_save_in = 0;
    idle();
    `CHK("nv_route", 8'h03, u_nv.mem[4])
    reset_n_in = 0;
    repeat (2) @(posedge clk_sys_in);
    #1 reset_n_in = 1;
    idle();
    `CHK("reload", 11'h1C4, ctrl_out)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    #1 reset_n_in = 1;
    t_load();
    t_modes();
    t_cal();
    t_save();
    wrap_up();
  end
endmodule
bind cspmc_top cspmc_props u_props (.*);
